// file: inc/sram_port_map.vh
/*
  Constants for the quad-rate SRAM read/write port model: timing counts
  and reset values. Assumes a 25 MHz core clock that
  oversamples every pin of the link.
*/
// Contract
// - Bypass input low: run without PLL, slow clocks allowed, read latency one cycle.
// - With PLL, input and output clock period must not exceed 8.4 ns; the lock model does not check the period.
// - Allow at least 20 us of PLL lock time after clock is stable.
// - Reset the PLL whenever the primary input clock stays static 30 ns or more.
// - Address and selects on primary clock rise; write data on both clock rises.
// - Read outputs go high impedance 2.5 cycles after last read with no follower; in bypass the model releases them after 2.0.
// - First burst word from the given address, second from address plus one.
// - A read of the address just written returns the fresh write data.
// - With both output clocks tied high, time outputs from the input clock pair.
`ifndef SRAM_PORT_MAP_VH
`define SRAM_PORT_MAP_VH

// Core clock period in picoseconds (25 MHz).
`define CORE_PERIOD_PS 40000
// Longest average clock period with the PLL in use, in picoseconds (8.4 ns).
`define PLL_MAX_PERIOD_PS 8400
// Least PLL lock time in microseconds.
`define PLL_LOCK_US 20
// Least static time of the primary clock that resets the PLL, in nanoseconds.
`define PLL_STATIC_NS 30
// Read latency in half cycles: 3 with the PLL, 2 in bypass mode.
`define READ_LAT_PLL_HALF 3'h3
`define READ_LAT_BYPASS_HALF 3'h2
// Extra half cycles a read port stays driven after its last word.
`define READ_TAIL_HALF 0
// Reset values; the address bit is replicated to the address width.
`define RESET_ADDR 1'b0

`endif

// file: rtl/edge_sync.v
/*
  Two-flop synchroniser with a rising-edge detector behind it.
  Assumes the input is asynchronous to clk and stays at each level for at
  least two clock periods.
*/
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  input wire clk,
  input wire rst,
  input wire din,
  output wire level,
  output wire rise
);
  reg meta;
  reg stable;
  reg last;

  // Outside reset the first stage feeds only the second, so no logic sees a metastable value.
  always @(posedge clk) begin
    if (rst) begin
      // Track the pin through reset so a pin that idles high gives no false
      // rise once reset ends; stable and last load alike, so rise stays low.
      meta <= din;
      stable <= meta;
      last <= meta;
    end else begin
      meta <= din;
      stable <= meta;
      last <= stable;
    end
  end

  assign level = stable;
  assign rise = stable & ~last;
endmodule // edge_sync
`default_nettype wire

// file: rtl/sram_rw_port.v
/*
  Read/write port of a synchronous quad-rate SRAM with a two-word burst.
  The core clock oversamples the controller's input clock pair, output
  clock pair and all other pins; each sampled clock rise is one event.
  Assumes the link clocks run at least four times slower than CORE_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_map.vh"
module sram_rw_port #(
  parameter AW = 6,
  parameter DW = 8,
  parameter BW = 1,
  parameter LOCK_CYCLES = 500,
  // Core cycles without a primary clock change that reset the PLL. The 30 ns figure
  // rounds up to one core cycle, so a slow link clock needs a larger value: it must
  // outlast the longest legal half period of IN_CLK_P, or lock is never held.
  parameter STATIC_CYCLES = (`PLL_STATIC_NS * 1000 + `CORE_PERIOD_PS - 1) / `CORE_PERIOD_PS
) (
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire IN_CLK_P,
  input wire IN_CLK_N,
  input wire OUT_CLK_P,
  input wire OUT_CLK_N,
  input wire PLL_BYPASS_N,
  input wire READ_SEL_N,
  input wire WRITE_SEL_N,
  input wire [AW-1:0] ADDR,
  input wire [DW-1:0] WRITE_DATA,
  input wire [BW-1:0] BYTE_WRITE_SELECT_N,
  output reg [DW-1:0] READ_DATA,
  output reg READ_DATA_OE_N,
  output reg ECHO_CLOCK_P,
  output reg ECHO_CLOCK_N,
  output wire PLL_LOCKED
);
  // Static-clock detect threshold, at least one cycle.
  localparam integer STATIC_CYC = (STATIC_CYCLES < 1) ? 1 : STATIC_CYCLES;
  localparam [AW-1:0] RST_A = {AW{`RESET_ADDR}};
  localparam integer LB = DW / BW;
  localparam integer DEPTH = 1 << AW;

  wire kp_lvl, kp_rise, kn_rise, cp_lvl, cp_rise, cn_lvl, cn_rise;
  wire rd_s, wr_s, byp_s;
  wire [AW-1:0] a_s;
  wire [DW-1:0] d_s;
  wire [BW-1:0] bw_s;

  edge_sync u_kp (.clk(CORE_CLK), .rst(SYS_RST), .din(IN_CLK_P), .level(kp_lvl), .rise(kp_rise));
  edge_sync u_kn (.clk(CORE_CLK), .rst(SYS_RST), .din(IN_CLK_N), .level(), .rise(kn_rise));
  edge_sync u_cp (.clk(CORE_CLK), .rst(SYS_RST), .din(OUT_CLK_P), .level(cp_lvl), .rise(cp_rise));
  edge_sync u_cn (.clk(CORE_CLK), .rst(SYS_RST), .din(OUT_CLK_N), .level(cn_lvl), .rise(cn_rise));

  // Data pins pass two flops; they share the clock-edge latency so they line up.
  reg [AW+DW+BW+2:0] pin_meta;
  reg [AW+DW+BW+2:0] pin_sync;
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pin_meta <= {(AW+DW+BW+3){1'b1}};
      pin_sync <= {(AW+DW+BW+3){1'b1}};
    end else begin
      pin_meta <= {PLL_BYPASS_N, READ_SEL_N, WRITE_SEL_N, ADDR, WRITE_DATA, BYTE_WRITE_SELECT_N};
      pin_sync <= pin_meta;
    end
  end
  assign {byp_s, rd_s, wr_s, a_s, d_s, bw_s} = pin_sync;
  wire bypass = ~byp_s;

  // Output clocks tied high select the input pair as output timing reference.
  wire use_k = cp_lvl & cn_lvl;
  wire ref_p = use_k ? kp_rise : cp_rise;
  wire ref_n = use_k ? kn_rise : cn_rise;

  // PLL model: a static primary clock resets lock, then the lock count restarts.
  // The period check against 8.4 ns cannot be resolved by a 40 ns sampler, so the
  // lock model only guards the stopped-clock case.
  reg [15:0] static_cnt;
  reg [31:0] lock_cnt;
  reg kp_prev;
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      static_cnt <= 16'h0000;
      lock_cnt <= 32'h0000_0000;
      kp_prev <= 1'b0;
    end else begin
      kp_prev <= kp_lvl;
      if (kp_lvl != kp_prev) begin
        static_cnt <= 16'h0000;
      end else if (static_cnt < STATIC_CYC[15:0]) begin
        static_cnt <= static_cnt + 16'h0001;
      end
      if (static_cnt >= STATIC_CYC[15:0]) begin
        lock_cnt <= 32'h0000_0000;
      end else if (lock_cnt < LOCK_CYCLES) begin
        lock_cnt <= lock_cnt + 32'h0000_0001;
      end
    end
  end
  assign PLL_LOCKED = bypass | (lock_cnt >= LOCK_CYCLES);

  // Array and write capture.
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_addr;
  reg [DW-1:0] wd0;
  reg [BW-1:0] wb0;
  reg wr_half;
  reg [AW-1:0] last_wr_addr;
  reg [DW-1:0] last_wd0;
  reg [DW-1:0] last_wd1;
  reg last_wr_valid;
  reg rd_go;
  reg [DW-1:0] rword0;
  reg [DW-1:0] rword1;

  // Merge byte lanes of new data over old where the lane select is low.
  function [DW-1:0] merge;
    input [DW-1:0] old;
    input [DW-1:0] nw;
    input [BW-1:0] sel_n;
    integer k;
    begin
      merge = old;
      for (k = 0; k < DW; k = k + 1) begin
        if (!sel_n[k / LB]) merge[k] = nw[k];
      end
    end
  endfunction

  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      wr_half <= 1'b0;
      wr_addr <= RST_A;
      wd0 <= {DW{1'b0}};
      wb0 <= {BW{1'b1}};
      last_wr_valid <= 1'b0;
      last_wr_addr <= RST_A;
      last_wd0 <= {DW{1'b0}};
      last_wd1 <= {DW{1'b0}};
      rd_go <= 1'b0;
      rword0 <= {DW{1'b0}};
      rword1 <= {DW{1'b0}};
    end else begin
      rd_go <= 1'b0;
      if (kp_rise) begin
        // Address and selects are taken only on the primary clock rise.
        if (!wr_s) begin
          wr_addr <= a_s;
          wd0 <= d_s;
          wb0 <= bw_s;
          wr_half <= 1'b1;
        end
        if (!rd_s) begin
          rd_go <= 1'b1;
          // Forward burst data of the last write rather than the stale array.
          if (last_wr_valid && last_wr_addr == a_s) begin
            rword0 <= last_wd0;
            rword1 <= last_wd1;
          end else begin
            rword0 <= mem[a_s];
            rword1 <= mem[a_s + {{(AW-1){1'b0}}, 1'b1}];
          end
        end
      end else if (kn_rise && wr_half) begin
        // Second write word rides the complementary clock rise.
        wr_half <= 1'b0;
        last_wr_valid <= 1'b1;
        last_wr_addr <= wr_addr;
        last_wd0 <= merge(mem[wr_addr], wd0, wb0);
        last_wd1 <= merge(mem[wr_addr + {{(AW-1){1'b0}}, 1'b1}], d_s, bw_s);
      end
    end
  end

  // Array update once the burst is complete.
  always @(posedge CORE_CLK) begin
    if (kn_rise && wr_half && !SYS_RST) begin
      mem[wr_addr] <= merge(mem[wr_addr], wd0, wb0);
      mem[wr_addr + {{(AW-1){1'b0}}, 1'b1}] <= merge(mem[wr_addr + {{(AW-1){1'b0}}, 1'b1}], d_s, bw_s);
    end
  end

  // Read output sequencer, counted in output-reference half cycles.
  reg [2:0] half_cnt;
  reg [1:0] words_left;
  reg busy;
  reg [DW-1:0] w1_hold;
  wire ref_edge = ref_p | ref_n;
  wire [2:0] lat = bypass ? `READ_LAT_BYPASS_HALF : `READ_LAT_PLL_HALF;
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      half_cnt <= 3'h0;
      words_left <= 2'h0;
      busy <= 1'b0;
      w1_hold <= {DW{1'b0}};
      READ_DATA <= {DW{1'b0}};
      READ_DATA_OE_N <= 1'b1;
      ECHO_CLOCK_P <= 1'b0;
      ECHO_CLOCK_N <= 1'b0;
    end else begin
      // Echo clocks follow the output reference so data and strobe travel together.
      if (ref_p) begin
        ECHO_CLOCK_P <= 1'b1;
        ECHO_CLOCK_N <= 1'b0;
      end else if (ref_n) begin
        ECHO_CLOCK_P <= 1'b0;
        ECHO_CLOCK_N <= 1'b1;
      end
      if (rd_go) begin
        busy <= 1'b1;
        half_cnt <= 3'h0;
        w1_hold <= rword1;
        words_left <= 2'h2;
      end else if (busy && ref_edge) begin
        if (half_cnt + 3'h1 >= lat) begin
          // Word zero then word one on successive reference edges.
          if (words_left == 2'h2) begin
            READ_DATA <= rword0;
            READ_DATA_OE_N <= 1'b0;
            words_left <= 2'h1;
          end else if (words_left == 2'h1) begin
            READ_DATA <= w1_hold;
            words_left <= 2'h0;
          end else begin
            // No read followed: release the bus half a cycle after word one.
            READ_DATA_OE_N <= 1'b1;
            busy <= 1'b0;
          end
        end else begin
          half_cnt <= half_cnt + 3'h1;
        end
      end
    end
  end
endmodule // sram_rw_port
`default_nettype wire

// file: bench/sram_rw_port_assertions.sv
/* Checker bound to sram_rw_port.
   Assumes link clocks of 8 core cycles a period. */
`timescale 1ns/1ps
`default_nettype none
module sram_rw_port_chk #(parameter LOCK_CYCLES = 500) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic IN_CLK_P,
  input wire logic OUT_CLK_N,
  input wire logic PLL_BYPASS_N,
  input wire logic READ_SEL_N,
  input wire logic READ_DATA_OE_N,
  input wire logic ECHO_CLOCK_P,
  input wire logic ECHO_CLOCK_N,
  input wire logic PLL_LOCKED,
  input wire logic OUT_CLK_P
);
  localparam int LKLO = LOCK_CYCLES;
  localparam int LKHI = LOCK_CYCLES + 24;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Read latency is 1.5 periods with the loop and 1.0 in bypass.
  a_lat_pll: assert property (PLL_BYPASS_N && !READ_SEL_N && $rose(IN_CLK_P) |->
    ##[12:20] $fell(READ_DATA_OE_N)) else $error("late read with loop");
  a_lat_bypass: assert property (!PLL_BYPASS_N && !READ_SEL_N && $rose(IN_CLK_P) |->
    ##[8:15] $fell(READ_DATA_OE_N)) else $error("late read in bypass");
  // Outputs drive for one period and then release.
  a_oe_window: assert property ($fell(READ_DATA_OE_N) |=>
    !READ_DATA_OE_N [*5] ##[1:5] READ_DATA_OE_N) else $error("bad drive window");
  a_echo_tied: assert property ($rose(IN_CLK_P) && OUT_CLK_P && OUT_CLK_N |->
    ##[2:6] $rose(ECHO_CLOCK_P)) else $error("echo ignores input pair");
  a_echo_out: assert property ($rose(OUT_CLK_N) |-> ##[2:6] $rose(ECHO_CLOCK_N))
    else $error("echo ignores output pair");
  a_lock_hold: assert property ($fell(SYS_RST) && PLL_BYPASS_N |-> !PLL_LOCKED [*6])
    else $error("early lock");
  a_lock_rise: assert property ($fell(SYS_RST) && PLL_BYPASS_N |->
    ##[LKLO:LKHI] PLL_LOCKED) else $error("no lock");
  a_lock_static: assert property ((PLL_BYPASS_N && $stable(IN_CLK_P)) [*8] |->
    ##[0:6] !PLL_LOCKED) else $error("lock kept on stopped clock");
  a_lock_bypass: assert property ($fell(SYS_RST) && !PLL_BYPASS_N |->
    ##[0:6] PLL_LOCKED) else $error("bypass not ready");
  c_rd_pll: cover property (PLL_BYPASS_N && !READ_SEL_N && $rose(IN_CLK_P));
  c_rd_byp: cover property (!PLL_BYPASS_N && !READ_SEL_N && $rose(IN_CLK_P));
  c_unlock: cover property ($fell(PLL_LOCKED));
endmodule // sram_rw_port_chk
bind sram_rw_port sram_rw_port_chk #(.LOCK_CYCLES(LOCK_CYCLES)) chk_i (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .IN_CLK_P(IN_CLK_P), .OUT_CLK_N(OUT_CLK_N),
  .PLL_BYPASS_N(PLL_BYPASS_N), .READ_SEL_N(READ_SEL_N), .READ_DATA_OE_N(READ_DATA_OE_N),
  .ECHO_CLOCK_P(ECHO_CLOCK_P), .ECHO_CLOCK_N(ECHO_CLOCK_N), .PLL_LOCKED(PLL_LOCKED),
  .OUT_CLK_P(OUT_CLK_P));
`default_nettype wire

// file: bench/sram_ctl_model.sv
/* Controller clock model: input pair of 320 ns, output pair.
   Assumes the bench sets run and c_tied. */
`timescale 1ns/1ps
`default_nettype none
module sram_ctl_model (
  input wire logic run,
  input wire logic c_tied,
  output logic IN_CLK_P,
  output logic IN_CLK_N,
  output wire logic OUT_CLK_P,
  output wire logic OUT_CLK_N
);
  // Halves of 160 ns keep every pulse wide; a stopped clock holds.
  initial begin
    IN_CLK_P = 1'b0;
    IN_CLK_N = 1'b1;
    #7;
    forever begin
      #160;
      if (run) begin
        IN_CLK_P = ~IN_CLK_P;
        IN_CLK_N = ~IN_CLK_N;
      end
    end
  end
  // Output pair trails by 20 ns, or sits high to select the input pair.
  assign #20 OUT_CLK_P = c_tied ? 1'b1 : IN_CLK_P;
  assign #20 OUT_CLK_N = c_tied ? 1'b1 : IN_CLK_N;
endmodule // sram_ctl_model
`default_nettype wire

// file: bench/tb_sram_rw_port.sv
/* Bench for sram_rw_port: random bursts, clock modes, stop, bypass.
   Assumes sram_ctl_model makes the link clocks. */
`timescale 1ns/1ps
`default_nettype none
module tb_sram_rw_port;
  logic CORE_CLK, SYS_RST, PLL_BYPASS_N, READ_SEL_N, WRITE_SEL_N, run, c_tied;
  logic [5:0] ADDR;
  logic [7:0] WRITE_DATA;
  logic [0:0] BYTE_WRITE_SELECT_N;
  wire [7:0] READ_DATA;
  wire IN_CLK_P, IN_CLK_N, OUT_CLK_P, OUT_CLK_N, READ_DATA_OE_N, ECHO_CLOCK_P, ECHO_CLOCK_N;
  wire PLL_LOCKED;
  logic [7:0] mem [64];
  logic [31:0] seed = 32'h41;
  int fail_count = 0, compares = 0, cyc = 0;
  sram_ctl_model sram_ctl_model_i (.run(run), .c_tied(c_tied), .IN_CLK_P(IN_CLK_P),
    .IN_CLK_N(IN_CLK_N), .OUT_CLK_P(OUT_CLK_P), .OUT_CLK_N(OUT_CLK_N));
  // A stop is six quiet core cycles, longer than the 4-cycle link half period.
  sram_rw_port #(.LOCK_CYCLES(8), .STATIC_CYCLES(6)) sram_rw_port_i (.CORE_CLK(CORE_CLK),
    .SYS_RST(SYS_RST),
    .IN_CLK_P(IN_CLK_P), .IN_CLK_N(IN_CLK_N), .OUT_CLK_P(OUT_CLK_P), .OUT_CLK_N(OUT_CLK_N),
    .PLL_BYPASS_N(PLL_BYPASS_N), .READ_SEL_N(READ_SEL_N), .WRITE_SEL_N(WRITE_SEL_N),
    .ADDR(ADDR), .WRITE_DATA(WRITE_DATA), .BYTE_WRITE_SELECT_N(BYTE_WRITE_SELECT_N),
    .READ_DATA(READ_DATA), .READ_DATA_OE_N(READ_DATA_OE_N), .ECHO_CLOCK_P(ECHO_CLOCK_P),
    .ECHO_CLOCK_N(ECHO_CLOCK_N), .PLL_LOCKED(PLL_LOCKED));
  // Core clock of 40 ns.
  initial begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // A high lane select keeps the old byte.
  function automatic logic [7:0] merge(input logic [7:0] old, nw, input logic s);
    return s ? old : nw;
  endfunction
  task automatic check(input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Changes wait two core cycles past a link edge, since the pins pass a synchroniser.
  task automatic op(input logic rd, wr, input logic [5:0] a, input logic [7:0] d0, d1,
                    input logic s0, s1);
    @(posedge IN_CLK_N);
    repeat (2) @(negedge CORE_CLK);
    {READ_SEL_N, WRITE_SEL_N, ADDR, WRITE_DATA, BYTE_WRITE_SELECT_N} = {~rd, ~wr, a, d0, s0};
    @(posedge IN_CLK_P);
    repeat (2) @(negedge CORE_CLK);
    {READ_SEL_N, WRITE_SEL_N, ADDR, WRITE_DATA, BYTE_WRITE_SELECT_N} = {2'b11, ~a, d1, s1};
    if (wr) begin
      mem[a] = merge(mem[a], d0, s0);
      mem[a + 6'h01] = merge(mem[a + 6'h01], d1, s1);
    end
  endtask
  // Keeps the first and last word of the burst.
  task automatic rd_chk(input logic [5:0] a);
    logic [7:0] w0, w1;
    int n = 0;
    int n0;
    op(1'b1, 1'b0, a, 8'h00, 8'h00, 1'b1, 1'b1);
    while (READ_DATA_OE_N !== 1'b0 && n < 40) begin
      @(negedge CORE_CLK);
      n++;
    end
    w0 = READ_DATA;
    n0 = n;
    w1 = 8'h00;
    while (READ_DATA_OE_N === 1'b0 && n < 80) begin
      w1 = READ_DATA;
      @(negedge CORE_CLK);
      n++;
    end
    check(w0, mem[a]);
    check(w1, mem[a + 6'h01]);
    // Each word stands half a link period (4 core cycles), then the bus is released.
    check(8'(n - n0), 8'h08);
  endtask
  task automatic traffic(input int cnt);
    logic [31:0] r;
    for (int i = 0; i < cnt; i++) begin
      r = rnd();
      if (i == 0) r[5:0] = 6'h3f;  // Second word wraps to zero.
      op(1'b0, 1'b1, r[5:0], r[15:8], r[23:16], r[24], r[25]);
      rd_chk(r[5:0]);
    end
  endtask
  task automatic set_tie(input logic v);
    // On a rising edge, so the model's 20 ns lag lands on a falling edge, clear of sampling.
    @(posedge IN_CLK_N);
    repeat (2) @(posedge CORE_CLK);
    c_tied = v;
  endtask
  // Cuts a hang short.
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      test_done();
    end
  end
  // Idle cycles while the loop settles and while the link clock is stopped.
  initial begin
    {SYS_RST, run, c_tied, PLL_BYPASS_N, READ_SEL_N, WRITE_SEL_N} = 6'h37;
    {ADDR, WRITE_DATA, BYTE_WRITE_SELECT_N} = 15'h0001;
    repeat (12) @(negedge CORE_CLK);
    SYS_RST = 1'b0;
    @(negedge CORE_CLK);
    check({7'h00, PLL_LOCKED}, 8'h00);
    repeat (40) @(negedge CORE_CLK);
    check({7'h00, PLL_LOCKED}, 8'h01);
    $display("lock done");
    for (int j = 0; j < 64; j += 2) op(1'b0, 1'b1, j[5:0], j[7:0], ~j[7:0], 1'b0, 1'b0);
    traffic(4);
    $display("traffic done");
    set_tie(1'b1);
    traffic(3);
    set_tie(1'b0);
    $display("tied done");
    run = 1'b0;
    repeat (20) @(negedge CORE_CLK);
    check({7'h00, PLL_LOCKED}, 8'h00);
    run = 1'b1;
    repeat (40) @(negedge CORE_CLK);
    check({7'h00, PLL_LOCKED}, 8'h01);
    $display("stop done");
    {PLL_BYPASS_N, SYS_RST} = 2'b01;
    repeat (3) @(negedge CORE_CLK);
    SYS_RST = 1'b0;
    repeat (6) @(negedge CORE_CLK);
    check({7'h00, PLL_LOCKED}, 8'h01);
    traffic(3);
    $display("bypass done");
    test_done();
  end
endmodule // tb_sram_rw_port
`default_nettype wire
